// ---- rtl/motion_inc_pkg.sv ----
package motion_inc_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_TS_LO = 10'h030;
  localparam logic [9:0] IDX_TS_MID = 10'h031;
  localparam logic [9:0] IDX_TS_HI = 10'h032;
  localparam logic [9:0] IDX_QUAT_W_LO = 10'h049;
  localparam logic [9:0] IDX_QUAT_Z_HI = 10'h050;
  localparam logic [9:0] IDX_VEL_X_LO = 10'h051;
  localparam logic [9:0] IDX_VEL_Z_HI = 10'h056;
  localparam logic [9:0] IDX_CLIP_FLAGS = 10'h057;
  localparam logic [9:0] IDX_OVF_FLAGS = 10'h058;
  localparam logic [9:0] IDX_FUSION_CTRL = 10'h070;
  localparam logic [9:0] IDX_MOTION_CMD = 10'h071;
  localparam logic [9:0] IDX_MOTION_STATUS = 10'h072;

  // Word address bits of paddr
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 11;

  // Fields of fusion_clip_flags
  localparam int BIT_BIAS_ACK = 6;
  localparam int BIT_RATE_Z_CLIP = 5;
  localparam int BIT_RATE_X_CLIP = 3;
  localparam int BIT_ACCEL_Z_CLIP = 2;
  localparam int BIT_ACCEL_X_CLIP = 0;

  // Fields of fusion_overflow_flags
  localparam int BIT_VELINC_Z_OVF = 2;
  localparam int BIT_VELINC_X_OVF = 0;

  // Fields of the fusion control register
  localparam int BIT_FUSION_ENABLE = 0;
  localparam int BIT_ACCEL_ENABLE = 1;
  localparam int BIT_GYRO_ENABLE = 2;
  localparam int BIT_MAGNET_ENABLE = 3;
  localparam int BIT_ON_DEMAND_SELECT = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // Command value that asks for the motion increments on demand
  localparam logic [7:0] CMD_REQUEST_MOTION = 8'h0c;

  // Status bit: on-demand data published, mirrors irq_motion_ready
  localparam int BIT_DATA_READY = 0;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] OVF_RESET = 3'h0;
  localparam logic [15:0] INC_RESET = 16'h0000;
  localparam logic [23:0] TS_RESET = 24'h000000;
  localparam logic [23:0] TS_STEP = 24'h000001;

endpackage

// ---- rtl/motion_increment_output_regs.sv ----
// Behaviour
// - Four signed 16-bit quaternion increments w,x,y,z, low then high byte, 0x49-0x50
// - Three signed 16-bit velocity increments x,y,z, low then high byte, 0x51-0x56
// - Bit 6 of clip flags: gyro bias updated in this output period, else zero
// - Bits 5,4,3 of clip flags: gyro z,y,x clipped during quaternion computation
// - Bits 2,1,0 of clip flags: accel z,y,x clipped during quaternion computation
// - Overflow flags at 0x58: velocity z,y,x overflow in bits 2..0, rest zero
// - On-demand request publishes increments so far and raises the first interrupt
module motion_increment_output_regs #(
  parameter int INC_W = 16,
  parameter int TS_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Fusion engine results, same clock
  input wire logic fusion_sample,
  input wire logic gyro_sample,
  input wire logic [INC_W-1:0] quat_inc_w,
  input wire logic [INC_W-1:0] quat_inc_x,
  input wire logic [INC_W-1:0] quat_inc_y,
  input wire logic [INC_W-1:0] quat_inc_z,
  input wire logic [INC_W-1:0] vel_inc_x,
  input wire logic [INC_W-1:0] vel_inc_y,
  input wire logic [INC_W-1:0] vel_inc_z,
  input wire logic bias_updated,
  input wire logic [2:0] rate_clipped,
  input wire logic [2:0] accel_clipped,
  input wire logic [2:0] velinc_overflow,
  // Mode outputs towards the engine and interrupt line
  output logic fusion_active,
  output logic on_demand_select,
  output logic magnet_enable,
  output logic irq_motion_ready
);

  // Elaboration check: byte split and counter width are fixed by the map
  if (INC_W != 16 || TS_W != 24) begin : g_width_check
    $error("motion_increment_output_regs supports only INC_W 16 and TS_W 24");
  end

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_e;

  typedef struct packed {
    bus_e bus;
    logic [31:0] rdata;
    logic slverr;
    logic [motion_inc_pkg::CTRL_W-1:0] ctrl;
    logic [3:0][INC_W-1:0] quat_out;
    logic [2:0][INC_W-1:0] vel_out;
    logic [7:0] clip_out;
    logic [2:0] ovf_out;
    logic [TS_W-1:0] ts_out;
    logic [3:0][INC_W-1:0] quat_acc;
    logic [2:0][INC_W-1:0] vel_acc;
    logic [6:0] clip_acc;
    logic [2:0] ovf_acc;
    logic [TS_W-1:0] fusion_count;
    logic [TS_W-1:0] window_count;
    logic data_ready;
  } state_s;

  state_s st;
  state_s next_st;

  logic access;
  logic [9:0] idx;
  logic [9:0] rel;
  logic active;
  logic demand;
  logic publish;
  logic status_read;
  logic [6:0] clip_now;
  logic [6:0] clip_period;
  logic [2:0] ovf_period;
  logic [TS_W-1:0] window_next;
  logic [TS_W-1:0] fusion_next;
  logic [3:0][INC_W-1:0] quat_now;
  logic [2:0][INC_W-1:0] vel_now;
  logic [31:0] rd_word;
  logic rd_hit;

  // Bus decode
  assign access = psel && penable;
  assign idx = paddr[motion_inc_pkg::ADDR_MSB:motion_inc_pkg::ADDR_LSB];
  assign pready = access && (st.bus == BUS_ACK);
  assign prdata = st.rdata;
  assign pslverr = st.slverr;

  // Mode outputs
  assign active = st.ctrl[motion_inc_pkg::BIT_FUSION_ENABLE] && st.ctrl[motion_inc_pkg::BIT_ACCEL_ENABLE]
                  && st.ctrl[motion_inc_pkg::BIT_GYRO_ENABLE];
  assign fusion_active = active;
  assign on_demand_select = st.ctrl[motion_inc_pkg::BIT_ON_DEMAND_SELECT];
  assign magnet_enable = st.ctrl[motion_inc_pkg::BIT_MAGNET_ENABLE];
  assign irq_motion_ready = st.data_ready;

  // Latest engine values, as one vector per group
  assign quat_now = {quat_inc_z, quat_inc_y, quat_inc_x, quat_inc_w};
  assign vel_now = {vel_inc_z, vel_inc_y, vel_inc_x};

  // Per-sample flag bits in clip-register order
  assign clip_now = {bias_updated, rate_clipped, accel_clipped};

  // Flags gathered over the running output period, including this cycle
  assign clip_period = st.clip_acc | (fusion_sample ? clip_now : 7'h00);
  assign ovf_period = st.ovf_acc | (fusion_sample ? velinc_overflow : 3'h0);

  // Sample counters; the 24-bit add wraps to zero by itself
  assign fusion_next = st.fusion_count + motion_inc_pkg::TS_STEP;
  assign window_next = st.window_count + (gyro_sample ? motion_inc_pkg::TS_STEP : motion_inc_pkg::TS_RESET);

  // On-demand request: a completed write of the request command
  assign demand = pready && pwrite && (idx == motion_inc_pkg::IDX_MOTION_CMD) && pstrb[0]
                  && (pwdata[7:0] == motion_inc_pkg::CMD_REQUEST_MOTION)
                  && active && on_demand_select;

  // Publishing: each fusion sample in periodic mode, each request on demand
  assign publish = active && (on_demand_select ? demand : fusion_sample);

  // Reading the status register acknowledges the interrupt
  assign status_read = pready && !pwrite && (idx == motion_inc_pkg::IDX_MOTION_STATUS);

  // Read mux over the whole map; unmapped words answer an error
  always_comb begin
    rel = 10'h000;
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    if (idx >= motion_inc_pkg::IDX_QUAT_W_LO && idx <= motion_inc_pkg::IDX_QUAT_Z_HI) begin
      rel = idx - motion_inc_pkg::IDX_QUAT_W_LO;
      rd_word[7:0] = rel[0] ? st.quat_out[rel[2:1]][15:8] : st.quat_out[rel[2:1]][7:0];
    end else if (idx >= motion_inc_pkg::IDX_VEL_X_LO && idx <= motion_inc_pkg::IDX_VEL_Z_HI) begin
      rel = idx - motion_inc_pkg::IDX_VEL_X_LO;
      rd_word[7:0] = rel[0] ? st.vel_out[rel[2:1]][15:8] : st.vel_out[rel[2:1]][7:0];
    end else begin
      unique case (idx)
        motion_inc_pkg::IDX_CLIP_FLAGS: rd_word[7:0] = st.clip_out;
        motion_inc_pkg::IDX_OVF_FLAGS: rd_word[2:0] = st.ovf_out;
        motion_inc_pkg::IDX_TS_LO: rd_word[7:0] = st.ts_out[7:0];
        motion_inc_pkg::IDX_TS_MID: rd_word[7:0] = st.ts_out[15:8];
        motion_inc_pkg::IDX_TS_HI: rd_word[7:0] = st.ts_out[23:16];
        motion_inc_pkg::IDX_FUSION_CTRL: rd_word[motion_inc_pkg::CTRL_W-1:0] = st.ctrl;
        motion_inc_pkg::IDX_MOTION_CMD: rd_word = 32'h00000000;
        motion_inc_pkg::IDX_MOTION_STATUS: rd_word[motion_inc_pkg::BIT_DATA_READY] = st.data_ready;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Next-state logic
  always_comb begin
    next_st = st;

    // APB: one wait cycle so read data comes from a flip-flop
    unique case (st.bus)
      BUS_IDLE: begin
        if (access) begin
          next_st.bus = BUS_ACK;
          next_st.rdata = pwrite ? 32'h00000000 : rd_word;
          next_st.slverr = !rd_hit;
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
      end
    endcase

    // Control register write, lane 0 only
    if (pready && pwrite && (idx == motion_inc_pkg::IDX_FUSION_CTRL) && pstrb[0]) begin
      next_st.ctrl = pwdata[motion_inc_pkg::CTRL_W-1:0];
    end

    // Engine results since the last publish: newest increments and sticky flags
    if (fusion_sample) begin
      next_st.quat_acc = quat_now;
      next_st.vel_acc = vel_now;
    end
    next_st.clip_acc = clip_period;
    next_st.ovf_acc = ovf_period;
    next_st.window_count = active ? window_next : motion_inc_pkg::TS_RESET;

    // Output update
    if (publish) begin
      next_st.quat_out = on_demand_select ? (fusion_sample ? quat_now : st.quat_acc) : quat_now;
      next_st.vel_out = on_demand_select ? (fusion_sample ? vel_now : st.vel_acc) : vel_now;
      next_st.clip_out = {1'b0, clip_period};
      next_st.ovf_out = ovf_period;
      next_st.clip_acc = 7'h00;
      next_st.ovf_acc = 3'h0;
      if (on_demand_select) begin
        next_st.ts_out = window_next;
        next_st.window_count = motion_inc_pkg::TS_RESET;
      end else begin
        next_st.ts_out = fusion_next;
        next_st.fusion_count = fusion_next;
      end
    end

    // Periodic count clears to zero whenever fusion is switched off or on-demand mode is selected
    if (!active || on_demand_select) begin
      next_st.fusion_count = motion_inc_pkg::TS_RESET;
    end

    // Interrupt: set by a request, cleared by a status read, set wins
    if (status_read) begin
      next_st.data_ready = 1'b0;
    end
    if (demand) begin
      next_st.data_ready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.bus <= BUS_IDLE;
      st.rdata <= 32'h00000000;
      st.slverr <= 1'b0;
      st.ctrl <= motion_inc_pkg::CTRL_RESET;
      st.quat_out <= {4{motion_inc_pkg::INC_RESET}};
      st.vel_out <= {3{motion_inc_pkg::INC_RESET}};
      st.clip_out <= motion_inc_pkg::FLAGS_RESET;
      st.ovf_out <= motion_inc_pkg::OVF_RESET;
      st.ts_out <= motion_inc_pkg::TS_RESET;
      st.quat_acc <= {4{motion_inc_pkg::INC_RESET}};
      st.vel_acc <= {3{motion_inc_pkg::INC_RESET}};
      st.clip_acc <= 7'h00;
      st.ovf_acc <= motion_inc_pkg::OVF_RESET;
      st.fusion_count <= motion_inc_pkg::TS_RESET;
      st.window_count <= motion_inc_pkg::TS_RESET;
      st.data_ready <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

endmodule // motion_increment_output_regs

// ---- tb/motion_inc_checker.sv ----
module motion_inc_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Mode and interrupt
  input wire logic fusion_active,
  input wire logic on_demand_select,
  input wire logic irq_motion_ready
);
  logic [9:0] idx;
  // Word index of the access
  assign idx = paddr[11:2];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus handshake and read data
  setup_wait_a: assert property (psel && !penable |=> !pready) else $error("pready in first access");
  one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no pready after wait");
  byte_lane_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  mapped_ok_a: assert property (pready && idx >= motion_inc_pkg::IDX_QUAT_W_LO &&
    idx <= motion_inc_pkg::IDX_OVF_FLAGS |-> !pslverr) else $error("error on result register");
  clip_rsvd_a: assert property (pready && !pwrite && idx == motion_inc_pkg::IDX_CLIP_FLAGS
    |-> !prdata[7]) else $error("clip flags bit 7 set");
  ovf_rsvd_a: assert property (pready && !pwrite && idx == motion_inc_pkg::IDX_OVF_FLAGS
    |-> prdata[7:3] == 5'h0) else $error("overflow reserved bits set");
  // On-demand interrupt
  irq_raise_a: assert property (pready && pwrite && pstrb[0] && idx == motion_inc_pkg::IDX_MOTION_CMD
    && pwdata[7:0] == motion_inc_pkg::CMD_REQUEST_MOTION && fusion_active && on_demand_select
    |=> irq_motion_ready) else $error("request did not raise irq");
  irq_cause_a: assert property ($rose(irq_motion_ready) |-> $past(fusion_active)
    && $past(on_demand_select)) else $error("irq outside on-demand mode");
endmodule // motion_inc_checker

bind motion_increment_output_regs motion_inc_checker checker_inst (.*);

// ---- tb/motion_increment_output_regs_tb.sv ----
module motion_increment_output_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, fusion_sample, gyro_sample, bias_updated, err;
  logic pready, pslverr, fusion_active, on_demand_select, magnet_enable, irq_motion_ready;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] inc [7];
  logic [2:0] rate_clipped, accel_clipped, velinc_overflow;
  int errors, checked;

  // Device under test
  motion_increment_output_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fusion_sample(fusion_sample), .gyro_sample(gyro_sample), .quat_inc_w(inc[0]),
    .quat_inc_x(inc[1]), .quat_inc_y(inc[2]), .quat_inc_z(inc[3]), .vel_inc_x(inc[4]),
    .vel_inc_y(inc[5]), .vel_inc_z(inc[6]), .bias_updated(bias_updated), .rate_clipped(rate_clipped),
    .accel_clipped(accel_clipped), .velinc_overflow(velinc_overflow), .fusion_active(fusion_active),
    .on_demand_select(on_demand_select), .magnet_enable(magnet_enable), .irq_motion_ready(irq_motion_ready));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task summarize;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; pready and the answer are sampled at the rising edge
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {20'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [9:0] i, input logic [7:0] exp, input logic exp_err);
    apb(1'b0, i, 8'h00);
    check(rd, {24'h0, exp});
    check({31'h0, err}, {31'h0, exp_err});
  endtask

  // One engine result; flags are {overflow, bias, rate, accel}
  task sample(input logic [15:0] b, input logic [9:0] f);
    @(posedge pclk);
    fusion_sample <= 1'b1;
    for (int i = 0; i < 7; i++) inc[i] <= b + 16'(i) * 16'h0203;
    {velinc_overflow, bias_updated, rate_clipped, accel_clipped} <= f;
    @(posedge pclk);
    fusion_sample <= 1'b0;
  endtask

  task chk_incs(input logic [15:0] b);
    logic [15:0] v;
    for (int i = 0; i < 7; i++) begin
      v = b + 16'(i) * 16'h0203;
      rd_chk(10'h049 + 10'(2 * i), v[7:0], 1'b0);
      rd_chk(10'h04a + 10'(2 * i), v[15:8], 1'b0);
    end
  endtask

  task reset_values;
    apb(1'b1, 10'h049, 8'hff);
    for (int i = 'h49; i <= 'h58; i++) rd_chk(10'(i), 8'h00, 1'b0);
    rd_chk(10'h040, 8'h00, 1'b1);
  endtask

  task periodic_flags;
    apb(1'b1, 10'h070, 8'h0f);
    @(negedge pclk);
    check({30'h0, fusion_active, magnet_enable}, 32'h3);
    sample(16'h8001, 10'b110_1_101_010);
    chk_incs(16'h8001);
    rd_chk(10'h057, 8'h6a, 1'b0);
    rd_chk(10'h058, 8'h06, 1'b0);
    rd_chk(10'h030, 8'h01, 1'b0);
    sample(16'h1234, 10'h000);
    rd_chk(10'h057, 8'h00, 1'b0);
    rd_chk(10'h058, 8'h00, 1'b0);
    rd_chk(10'h030, 8'h02, 1'b0);
    rd_chk(10'h031, 8'h00, 1'b0);
  endtask

  task on_demand;
    apb(1'b1, 10'h071, 8'h0c);
    @(negedge pclk);
    check({31'h0, irq_motion_ready}, 32'h0);
    apb(1'b1, 10'h070, 8'h17);
    @(posedge pclk);
    gyro_sample <= 1'b1;
    repeat (3) @(posedge pclk);
    gyro_sample <= 1'b0;
    sample(16'hc00d, 10'h000);
    rd_chk(10'h049, 8'h34, 1'b0);
    apb(1'b1, 10'h071, 8'h0c);
    @(negedge pclk);
    check({31'h0, irq_motion_ready}, 32'h1);
    chk_incs(16'hc00d);
    rd_chk(10'h030, 8'h03, 1'b0);
    rd_chk(10'h072, 8'h01, 1'b0);
    @(negedge pclk);
    check({31'h0, irq_motion_ready}, 32'h0);
  endtask

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, fusion_sample, gyro_sample, bias_updated} = 7'h0;
    {paddr, pwdata, rate_clipped, accel_clipped, velinc_overflow} = '0;
    pstrb = 4'h1;
    for (int i = 0; i < 7; i++) inc[i] = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    periodic_flags();
    on_demand();
    summarize();
  end
endmodule // motion_increment_output_regs_tb
